// File: dpb_pkg.sv
// Shared constants, register map and state codes for the parallel DAC host controller.
package dpb_pkg;
	localparam int CLK_NS = 20;
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFF_CTRL   = 5'h00;
	localparam logic [4:0] OFF_DATA   = 5'h04;
	localparam logic [4:0] OFF_CMD    = 5'h08;
	localparam logic [4:0] OFF_STATUS = 5'h0C;
	localparam logic [4:0] OFF_DAC    = 5'h10;
	localparam int CTRL_SYNC = 0;
	localparam int CTRL_BUF  = 1;
	localparam int CTRL_GAIN = 2;
	localparam int CTRL_PD   = 3;
	localparam logic CTRL_SYNC_RST = 1'h0;
	localparam logic CTRL_BUF_RST  = 1'h0;
	localparam logic CTRL_GAIN_RST = 1'h0;
	localparam logic CTRL_PD_RST   = 1'h0;
	localparam int CMD_LOAD  = 0;
	localparam int CMD_CLEAR = 1;
	localparam int STAT_BUSY   = 0;
	localparam int STAT_PEND   = 1;
	localparam int STAT_DROP   = 2;
	localparam int STAT_INCODE = 16;
	localparam int DAC_BUF  = 16;
	localparam int DAC_GAIN = 17;
	localparam int BYTE_W    = 8;
	localparam int HI_NIB_W  = 4;
	localparam int HI_GAIN   = 6;
	localparam int HI_BUF    = 7;
	localparam int BYTE_CODE_W = 12;
	localparam int T_SETUP_NS = 20;
	localparam int T_PULSE_NS = 40;
	localparam int T_HOLD_NS  = 20;

	// Least times round up, and no phase is shorter than one cycle.
	function automatic int ns2cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns2cyc

	localparam int SETUP_CYC = ns2cyc(T_SETUP_NS);
	localparam int PULSE_CYC = ns2cyc(T_PULSE_NS);
	localparam int HOLD_CYC  = ns2cyc(T_HOLD_NS);

	typedef enum logic [2:0] {
		S_IDLE   = 3'h0,
		S_SETUP  = 3'h1,
		S_STROBE = 3'h2,
		S_HOLD   = 3'h3,
		S_LOAD   = 3'h4,
		S_CLEAR  = 3'h5
	} dpb_state_t;
endpackage : dpb_pkg

// File: dpb_timer.sv
// Down-counter that times each phase of the pin sequence.
`timescale 1ns/1ps
module dpb_timer #(
	parameter int CW = 4
) (
	input  wire logic          core_clk,
	input  wire logic          srst,
	input  wire logic          start,
	input  wire logic [CW-1:0] len,
	output logic               expire
);
	typedef struct packed {
		logic [CW-1:0] cnt;
	} dpb_tmr_st_t;

	dpb_tmr_st_t q_ff;
	dpb_tmr_st_t nxt_q;

	if (CW < 2) begin : g_chk
		$error("dpb_timer: CW must be at least 2.");
	end

	always_comb begin
		nxt_q = q_ff;
		if (start) begin
			nxt_q.cnt = len;
		end else if (q_ff.cnt != '0) begin
			nxt_q.cnt = q_ff.cnt - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// A phase loaded with len lasts exactly len cycles.
	assign expire = (q_ff.cnt == CW'(1));
endmodule : dpb_timer

// File: dpb_fmt.sv
// Maps the held code, and in the byte variant the settings, onto the parallel data lines.
`timescale 1ns/1ps
module dpb_fmt #(
	parameter int DATA_W    = 12,
	parameter int LINES_W   = 12,
	parameter int BYTE_LOAD = 0
) (
	input  wire logic [DATA_W-1:0]  code,
	input  wire logic               hi,
	input  wire logic               buf_sel,
	input  wire logic               gain_sel,
	output logic      [LINES_W-1:0] lines
);
	if (BYTE_LOAD != 0) begin : g_byte
		always_comb begin
			lines = '0;
			if (hi) begin
				lines[dpb_pkg::HI_NIB_W-1:0] = code[DATA_W-1:dpb_pkg::BYTE_W];
				lines[dpb_pkg::HI_GAIN] = gain_sel;
				lines[dpb_pkg::HI_BUF]  = buf_sel;
			end else begin
				lines = code[dpb_pkg::BYTE_W-1:0];
			end
		end
	end else begin : g_word
		assign lines = code;
	end
endmodule : dpb_fmt

// File: dpb_host.sv
// Host-side controller that drives the parallel double-buffered DAC pins.
//
// Behaviour
// - Word variants take the code in one write; byte variant uses two.
// - Host drives chip select low to select the device for a write.
// - Synchronous mode: DAC register updates right after the captured write.
// - Asynchronous mode: writes leave the output; only a load strobe updates.
// - Byte variant: byte select steers each write to high or low byte.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
module dpb_host #(
	parameter int DATA_W    = 12,
	parameter int BYTE_LOAD = 0,
	parameter int LINES_W   = (BYTE_LOAD != 0) ? dpb_pkg::BYTE_W : DATA_W,
	parameter int TCW       = 4
) (
	input  wire logic                      core_clk,
	input  wire logic                      srst,
	input  wire logic [dpb_pkg::ADDR_W-1:0] addr,
	input  wire logic [31:0]               wdata,
	input  wire logic                      wr_stb,
	input  wire logic                      rd_stb,
	output logic      [31:0]               rdata,
	output logic                           chip_select_n,
	output logic                           write_strobe_n,
	output logic                           load_strobe_n,
	output logic                           clear_n,
	output logic                           byte_select,
	output logic      [LINES_W-1:0]        data_lines,
	output logic                           buf_sel,
	output logic                           gain_sel,
	output logic                           power_down_n
);
	typedef struct packed {
		dpb_pkg::dpb_state_t st;
		logic                hi;
		logic [DATA_W-1:0]   code;
		logic                wbuf;
		logic                wgain;
		logic [DATA_W-1:0]   in_code;
		logic                in_buf;
		logic                in_gain;
		logic [DATA_W-1:0]   dac_code;
		logic                dac_buf;
		logic                dac_gain;
		logic                pend;
		logic                drop;
		logic                sync;
		logic                cbuf;
		logic                cgain;
		logic                pd;
		logic                cs_n;
		logic                wr_n;
		logic                ld_n;
		logic                clr_n;
		logic                bsel;
		logic [31:0]         rdata;
	} dpb_host_st_t;

	dpb_host_st_t q_ff;
	dpb_host_st_t nxt_q;
	logic         tmr_start;
	logic         tmr_done;
	logic [TCW-1:0] tmr_len;

	if ((BYTE_LOAD != 0 && (DATA_W != dpb_pkg::BYTE_CODE_W || LINES_W != dpb_pkg::BYTE_W))
	    || (BYTE_LOAD == 0 && LINES_W != DATA_W)
	    || (DATA_W != 8 && DATA_W != 10 && DATA_W != 12)
	    || dpb_pkg::PULSE_CYC >= (1 << TCW) || dpb_pkg::SETUP_CYC >= (1 << TCW)
	    || dpb_pkg::HOLD_CYC >= (1 << TCW)) begin : g_chk
		$error("dpb_host: unsupported width or timer size.");
	end

	function automatic logic [TCW-1:0] phase_len(input dpb_pkg::dpb_state_t s);
		unique case (s)
			dpb_pkg::S_SETUP:  phase_len = TCW'(dpb_pkg::SETUP_CYC);
			dpb_pkg::S_STROBE: phase_len = TCW'(dpb_pkg::PULSE_CYC);
			dpb_pkg::S_HOLD:   phase_len = TCW'(dpb_pkg::HOLD_CYC);
			dpb_pkg::S_LOAD:   phase_len = TCW'(dpb_pkg::PULSE_CYC);
			dpb_pkg::S_CLEAR:  phase_len = TCW'(dpb_pkg::PULSE_CYC);
			default:           phase_len = TCW'(1);
		endcase
	endfunction : phase_len

	always_comb begin
		logic upd;
		logic idle;
		upd = 1'b0;
		idle = (q_ff.st == dpb_pkg::S_IDLE);
		nxt_q = q_ff;
		nxt_q.rdata = '0;
		if (rd_stb) begin
			unique case (addr)
				dpb_pkg::OFF_CTRL: begin
					nxt_q.rdata[dpb_pkg::CTRL_SYNC] = q_ff.sync;
					nxt_q.rdata[dpb_pkg::CTRL_BUF]  = q_ff.cbuf;
					nxt_q.rdata[dpb_pkg::CTRL_GAIN] = q_ff.cgain;
					nxt_q.rdata[dpb_pkg::CTRL_PD]   = q_ff.pd;
				end
				dpb_pkg::OFF_DATA: nxt_q.rdata[DATA_W-1:0] = q_ff.code;
				dpb_pkg::OFF_STATUS: begin
					nxt_q.rdata[dpb_pkg::STAT_BUSY] = !idle;
					nxt_q.rdata[dpb_pkg::STAT_PEND] = q_ff.pend;
					nxt_q.rdata[dpb_pkg::STAT_DROP] = q_ff.drop;
					nxt_q.rdata[dpb_pkg::STAT_INCODE +: DATA_W] = q_ff.in_code;
					nxt_q.drop = 1'b0;
				end
				dpb_pkg::OFF_DAC: begin
					nxt_q.rdata[DATA_W-1:0]       = q_ff.dac_code;
					nxt_q.rdata[dpb_pkg::DAC_BUF]  = q_ff.dac_buf;
					nxt_q.rdata[dpb_pkg::DAC_GAIN] = q_ff.dac_gain;
				end
				default: nxt_q.rdata = '0;
			endcase
		end
		unique case (q_ff.st)
			dpb_pkg::S_SETUP: begin
				if (tmr_done) begin
					nxt_q.st = dpb_pkg::S_STROBE;
					nxt_q.wr_n = 1'b0;
				end
			end
			dpb_pkg::S_STROBE: begin
				if (tmr_done) begin
					nxt_q.st = dpb_pkg::S_HOLD;
					nxt_q.wr_n = 1'b1;
					if (BYTE_LOAD != 0 && q_ff.hi) begin
						nxt_q.in_code[DATA_W-1:dpb_pkg::BYTE_W] = q_ff.code[DATA_W-1:dpb_pkg::BYTE_W];
					end else if (BYTE_LOAD != 0) begin
						nxt_q.in_code[dpb_pkg::BYTE_W-1:0] = q_ff.code[dpb_pkg::BYTE_W-1:0];
					end else begin
						nxt_q.in_code = q_ff.code;
					end
					nxt_q.in_buf = q_ff.wbuf;
					nxt_q.in_gain = q_ff.wgain;
					nxt_q.pend = 1'b1;
				end
			end
			dpb_pkg::S_HOLD: begin
				if (tmr_done) begin
					if (BYTE_LOAD != 0 && !q_ff.hi) begin
						nxt_q.hi = 1'b1;
						nxt_q.bsel = 1'b1;
						nxt_q.st = dpb_pkg::S_SETUP;
					end else begin
						nxt_q.cs_n = 1'b1;
						nxt_q.bsel = 1'b0;
						if (q_ff.sync) begin
							nxt_q.st = dpb_pkg::S_LOAD;
							nxt_q.ld_n = 1'b0;
							upd = 1'b1;
						end else begin
							nxt_q.st = dpb_pkg::S_IDLE;
						end
					end
				end
			end
			dpb_pkg::S_LOAD: begin
				if (tmr_done) begin
					nxt_q.st = dpb_pkg::S_IDLE;
					nxt_q.ld_n = 1'b1;
				end
			end
			dpb_pkg::S_CLEAR: begin
				if (tmr_done) begin
					nxt_q.st = dpb_pkg::S_IDLE;
					nxt_q.clr_n = 1'b1;
				end
			end
			default: begin
				nxt_q.st = dpb_pkg::S_IDLE;
			end
		endcase
		if (wr_stb) begin
			unique case (addr)
				dpb_pkg::OFF_CTRL: begin
					nxt_q.sync  = wdata[dpb_pkg::CTRL_SYNC];
					nxt_q.cbuf  = wdata[dpb_pkg::CTRL_BUF];
					nxt_q.cgain = wdata[dpb_pkg::CTRL_GAIN];
					nxt_q.pd    = wdata[dpb_pkg::CTRL_PD];
				end
				dpb_pkg::OFF_DATA: begin
					if (idle) begin
						nxt_q.st = dpb_pkg::S_SETUP;
						nxt_q.cs_n = 1'b0;
						nxt_q.hi = 1'b0;
						nxt_q.bsel = 1'b0;
						nxt_q.code = wdata[DATA_W-1:0];
						nxt_q.wbuf = q_ff.cbuf;
						nxt_q.wgain = q_ff.cgain;
					end else begin
						nxt_q.drop = 1'b1;
					end
				end
				dpb_pkg::OFF_CMD: begin
					if (!idle && (wdata[dpb_pkg::CMD_CLEAR] || wdata[dpb_pkg::CMD_LOAD])) begin
						nxt_q.drop = 1'b1;
					end else if (wdata[dpb_pkg::CMD_CLEAR]) begin
						nxt_q.st = dpb_pkg::S_CLEAR;
						nxt_q.clr_n = 1'b0;
						nxt_q.in_code = '0;
						nxt_q.dac_code = '0;
						nxt_q.pend = 1'b0;
					end else if (wdata[dpb_pkg::CMD_LOAD]) begin
						nxt_q.st = dpb_pkg::S_LOAD;
						nxt_q.ld_n = 1'b0;
						upd = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		if (upd && q_ff.pend) begin
			nxt_q.dac_code = q_ff.in_code;
			nxt_q.dac_buf  = q_ff.in_buf;
			nxt_q.dac_gain = q_ff.in_gain;
			nxt_q.pend     = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			// Shadows start at zero, matching the device.
			q_ff       <= '0;
			q_ff.sync  <= dpb_pkg::CTRL_SYNC_RST;
			q_ff.cbuf  <= dpb_pkg::CTRL_BUF_RST;
			q_ff.cgain <= dpb_pkg::CTRL_GAIN_RST;
			q_ff.pd    <= dpb_pkg::CTRL_PD_RST;
			q_ff.cs_n  <= 1'b1;
			q_ff.wr_n  <= 1'b1;
			q_ff.ld_n  <= 1'b1;
			q_ff.clr_n <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign tmr_start = (nxt_q.st != q_ff.st);
	assign tmr_len   = phase_len(nxt_q.st);

	dpb_timer #(
		.CW (TCW)
	) u_timer (
		.core_clk (core_clk),
		.srst     (srst),
		.start    (tmr_start),
		.len      (tmr_len),
		.expire   (tmr_done)
	);

	// Lines are a fixed mux of held flops, so they stay stable across each strobe.
	dpb_fmt #(
		.DATA_W    (DATA_W),
		.LINES_W   (LINES_W),
		.BYTE_LOAD (BYTE_LOAD)
	) u_fmt (
		.code     (q_ff.code),
		.hi       (q_ff.hi),
		.buf_sel  (q_ff.wbuf),
		.gain_sel (q_ff.wgain),
		.lines    (data_lines)
	);

	assign rdata          = q_ff.rdata;
	assign chip_select_n  = q_ff.cs_n;
	assign write_strobe_n = q_ff.wr_n;
	assign load_strobe_n  = q_ff.ld_n;
	assign clear_n        = q_ff.clr_n;
	assign byte_select    = q_ff.bsel;
	assign buf_sel        = q_ff.wbuf;
	assign gain_sel       = q_ff.wgain;
	assign power_down_n   = !q_ff.pd;

	localparam int A_LD_MAX   = 8;
	localparam int A_PAIR_MAX = 16;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	sequence s_last_capture;
		$rose(write_strobe_n) && q_ff.sync && (BYTE_LOAD == 0 || q_ff.hi);
	endsequence
	sequence s_low_capture;
		(BYTE_LOAD != 0) && $rose(write_strobe_n) && !byte_select;
	endsequence
	sequence s_high_capture;
		$rose(write_strobe_n) && byte_select;
	endsequence

	property p_strobe_selected;
		!write_strobe_n |-> !chip_select_n;
	endproperty
	a_strobe_selected: assert property (p_strobe_selected) else $error("Write strobe low without select.");

	property p_edge_selected;
		$rose(write_strobe_n) |-> !chip_select_n && load_strobe_n;
	endproperty
	a_edge_selected: assert property (p_edge_selected) else $error("Rising write edge without select.");

	property p_sync_load;
		s_last_capture |-> ##[1:A_LD_MAX] ($fell(load_strobe_n) && q_ff.pend == 1'b0);
	endproperty
	a_sync_load: assert property (p_sync_load) else $error("Synchronous load did not follow write.");

	property p_async_quiet;
		(q_ff.st == dpb_pkg::S_HOLD && !q_ff.sync) |=> load_strobe_n && q_ff.pend;
	endproperty
	a_async_quiet: assert property (p_async_quiet) else $error("Load strobe moved in async mode.");

	property p_byte_pair;
		s_low_capture |-> ##[1:A_PAIR_MAX] s_high_capture;
	endproperty
	a_byte_pair: assert property (p_byte_pair) else $error("Low byte not followed by high byte.");

	property p_word_lines;
		(BYTE_LOAD == 0) && !write_strobe_n |-> data_lines == LINES_W'(q_ff.code);
	endproperty
	a_word_lines: assert property (p_word_lines) else $error("Word lines differ from code.");

	property p_clear_zero;
		(wr_stb && addr == dpb_pkg::OFF_CMD && wdata[dpb_pkg::CMD_CLEAR] && q_ff.st == dpb_pkg::S_IDLE)
			|=> !clear_n && q_ff.in_code == '0 && q_ff.dac_code == '0;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("Clear did not zero shadows.");
endmodule : dpb_host

// File: dpb_dev_model.sv
// Behavioural model of the double-buffered parallel DAC input logic.
`timescale 1ns/1ps
module dpb_dev_model #(
	parameter int DATA_W    = 12,
	parameter int BYTE_LOAD = 0,
	parameter int LINES_W   = 12
) (
	input  wire logic               chip_select_n,
	input  wire logic               write_strobe_n,
	input  wire logic               load_strobe_n,
	input  wire logic               clear_n,
	input  wire logic               byte_select,
	input  wire logic [LINES_W-1:0] data_lines,
	input  wire logic               buf_sel,
	input  wire logic               gain_sel,
	input  wire logic               power_down_n,
	output logic      [DATA_W-1:0]  in_code,
	output logic      [DATA_W-1:0]  dac_code,
	output logic                    dac_buf,
	output logic                    dac_gain,
	output logic                    pend,
	output logic      [1:0]         gain_factor
);
	logic in_buf;
	logic in_gain;

	// straight binary code, gain level 1 doubles, buffer level 1 buffers.
	assign gain_factor = dac_gain ? 2'h2 : 2'h1;

	// zero at power-on; the power-down pin is ignored on purpose.
	initial begin
		in_code = '0;
		dac_code = '0;
		{in_buf, in_gain, dac_buf, dac_gain, pend} = 5'h00;
	end

	task automatic update;
		if (pend) begin
			dac_code = in_code;
			dac_buf = in_buf;
			dac_gain = in_gain;
			pend = 1'b0;
		end
	endtask : update

	always @(negedge clear_n) begin
		in_code = '0;
		dac_code = '0;
		pend = 1'b0;
	end

	always @(posedge write_strobe_n) begin
		if (clear_n === 1'b1 && chip_select_n === 1'b0) begin
			if (BYTE_LOAD == 0) begin
				in_code = DATA_W'(data_lines);
			end else if (byte_select) begin
				in_code[11:8] = data_lines[3:0];
			end else begin
				in_code[7:0] = data_lines[7:0];
			end
			in_buf = buf_sel;
			in_gain = gain_sel;
			pend = 1'b1;
			if (load_strobe_n === 1'b0) begin
				update();
			end
		end
	end

	// a falling load edge moves data, and so does a write edge while load is held low.
	always @(negedge load_strobe_n) begin
		if (clear_n === 1'b1) begin
			update();
		end
	end
endmodule : dpb_dev_model

// File: test_dac_parallel_double_buffer.sv
// Self-checking bench for the host controller, word and byte variants.
`timescale 1ns/1ps
`define CHK(N, E, G) begin n_tests++; if ((G) !== (E)) begin fails++; \
	$display("unexpected %s expected %h seen %h", N, E, G); end end
module test_dac_parallel_double_buffer;
	logic                       core_clk;
	logic                       srst;
	logic [dpb_pkg::ADDR_W-1:0] addr;
	logic [31:0]                wdata;
	logic                       wr_stb;
	logic                       rd_stb;
	logic [7:0]                 hi_lines;
	logic [31:0]                stat_or;
	logic [31:0]                rv;
	logic [31:0]                rb;
	int                         fails;
	int                         n_tests;
	wire  [31:0]                rdata [2];
	wire  [1:0]                 cs_n, wstb_n, ld_n, clr_n, bsel, bufs, gains, pdn;
	wire  [1:0]                 dbuf, dgain, pend;
	wire  [11:0]                lines_w;
	wire  [7:0]                 lines_b;
	wire  [11:0]                in_code [2];
	wire  [11:0]                dac_code [2];
	wire  [1:0]                 gfac [2];

	dpb_host DUT (.core_clk(core_clk), .srst(srst), .addr(addr),
		.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata[0]),
		.chip_select_n(cs_n[0]), .write_strobe_n(wstb_n[0]), .load_strobe_n(ld_n[0]),
		.clear_n(clr_n[0]), .byte_select(bsel[0]), .data_lines(lines_w),
		.buf_sel(bufs[0]), .gain_sel(gains[0]), .power_down_n(pdn[0]));
	dpb_host #(.BYTE_LOAD(1)) DUT_B (.core_clk(core_clk), .srst(srst), .addr(addr),
		.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata[1]),
		.chip_select_n(cs_n[1]), .write_strobe_n(wstb_n[1]), .load_strobe_n(ld_n[1]),
		.clear_n(clr_n[1]), .byte_select(bsel[1]), .data_lines(lines_b),
		.buf_sel(bufs[1]), .gain_sel(gains[1]), .power_down_n(pdn[1]));
	dpb_dev_model dev_w (
		.chip_select_n(cs_n[0]), .write_strobe_n(wstb_n[0]), .load_strobe_n(ld_n[0]),
		.clear_n(clr_n[0]), .byte_select(bsel[0]), .data_lines(lines_w), .buf_sel(bufs[0]),
		.gain_sel(gains[0]), .power_down_n(pdn[0]), .in_code(in_code[0]),
		.dac_code(dac_code[0]), .dac_buf(dbuf[0]), .dac_gain(dgain[0]), .pend(pend[0]),
		.gain_factor(gfac[0]));
	dpb_dev_model #(.BYTE_LOAD(1), .LINES_W(8)) dev_b (
		.chip_select_n(cs_n[1]), .write_strobe_n(wstb_n[1]), .load_strobe_n(ld_n[1]),
		.clear_n(clr_n[1]), .byte_select(bsel[1]), .data_lines(lines_b), .buf_sel(bufs[1]),
		.gain_sel(gains[1]), .power_down_n(pdn[1]), .in_code(in_code[1]),
		.dac_code(dac_code[1]), .dac_buf(dbuf[1]), .dac_gain(dgain[1]), .pend(pend[1]),
		.gain_factor(gfac[1]));

	initial begin
		core_clk = 1'b0;
		forever #(dpb_pkg::CLK_NS / 2) core_clk = ~core_clk;
	end

	// select must be low whenever a write edge reaches the device.
	always @(posedge wstb_n[0]) if (!srst) `CHK("cs_n word", 1'b0, cs_n[0])
	// high-byte contents are kept for a later look.
	always @(posedge wstb_n[1]) begin
		if (!srst) `CHK("cs_n byte", 1'b0, cs_n[1])
		if (bsel[1] === 1'b1) hi_lines = lines_b;
	end

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge core_clk);
		wr_stb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [31:0] b);
		@(posedge core_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge core_clk);
		rd_stb <= 1'b0;
		#1;
		v = rdata[0];
		b = rdata[1];
	endtask : rd

	// Polling reads clear the sticky drop flag, so every word-variant status seen is kept in stat_or.
	task automatic wait_idle;
		int i;
		for (i = 0; i < 40; i++) begin
			rd(dpb_pkg::OFF_STATUS, rv, rb);
			stat_or = stat_or | rv;
			if (rv[0] === 1'b0 && rb[0] === 1'b0) break;
		end
		if (i == 40) `CHK("idle", 1'b1, 1'b0)
	endtask : wait_idle

	task automatic check_dev(input logic [11:0] ic, input logic [11:0] dc, input logic b,
		input logic g);
		for (int k = 0; k < 2; k++) begin
			`CHK("in_code", ic, in_code[k])
			`CHK("dac_code", dc, dac_code[k])
			`CHK("dac_buf", b, dbuf[k])
			`CHK("dac_gain", g, dgain[k])
		end
	endtask : check_dev

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		rd(a, rv, rb);
		`CHK("rdata", e, rv)
	endtask : rd_chk

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (5000) @(posedge core_clk);
		`CHK("watchdog", 1'b0, 1'b1)
		give_verdict();
	end

	initial begin
		{srst, addr, wdata, wr_stb, rd_stb} = {1'b1, 5'h00, 32'h0, 2'h0};
		{fails, n_tests, stat_or, hi_lines} = '0;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rd_chk(dpb_pkg::OFF_CTRL, 32'h0);
		rd_chk(dpb_pkg::OFF_STATUS, 32'h0);
		rd_chk(dpb_pkg::OFF_DAC, 32'h0);
		rd_chk(5'h14, 32'h0);
		check_dev(12'h000, 12'h000, 1'b0, 1'b0);
		`CHK("power_down_n", 2'h3, pdn)
		$display("test reset done");
		wr(dpb_pkg::OFF_CTRL, 32'h6);
		wr(dpb_pkg::OFF_DATA, 32'h0ABC);
		wait_idle();
		rd_chk(dpb_pkg::OFF_STATUS, 32'h0ABC_0002);
		check_dev(12'hABC, 12'h000, 1'b0, 1'b0);
		`CHK("pend", 2'h3, pend)
		rd_chk(dpb_pkg::OFF_DATA, 32'h0000_0ABC);
		`CHK("high byte", 8'hCA, hi_lines)
		wr(dpb_pkg::OFF_CMD, 32'h1);
		wait_idle();
		check_dev(12'hABC, 12'hABC, 1'b1, 1'b1);
		`CHK("gain", 2'h2, gfac[0])
		rd_chk(dpb_pkg::OFF_DAC, 32'h0003_0ABC);
		wr(dpb_pkg::OFF_CMD, 32'h1);
		wait_idle();
		check_dev(12'hABC, 12'hABC, 1'b1, 1'b1);
		`CHK("pend", 2'h0, pend)
		rd_chk(dpb_pkg::OFF_STATUS, 32'h0ABC_0000);
		$display("test async load done");
		wr(dpb_pkg::OFF_CTRL, 32'h1);
		wr(dpb_pkg::OFF_DATA, 32'h0FFF);
		wait_idle();
		check_dev(12'hFFF, 12'hFFF, 1'b0, 1'b0);
		`CHK("gain", 2'h1, gfac[1])
		stat_or = '0;
		wr(dpb_pkg::OFF_DATA, 32'h0123);
		wr(dpb_pkg::OFF_DATA, 32'h0456);
		wait_idle();
		`CHK("drop", 1'b1, stat_or[2])
		rd_chk(dpb_pkg::OFF_STATUS, 32'h0123_0000);
		check_dev(12'h123, 12'h123, 1'b0, 1'b0);
		$display("test sync load done");
		wr(dpb_pkg::OFF_CTRL, 32'h8);
		@(posedge core_clk);
		#1;
		`CHK("power_down_n", 2'h0, pdn)
		check_dev(12'h123, 12'h123, 1'b0, 1'b0);
		wr(dpb_pkg::OFF_CTRL, 32'h0);
		wr(dpb_pkg::OFF_CMD, 32'h3);
		wait_idle();
		check_dev(12'h000, 12'h000, 1'b0, 1'b0);
		rd_chk(dpb_pkg::OFF_DAC, 32'h0);
		rd_chk(dpb_pkg::OFF_STATUS, 32'h0);
		$display("test clear done");
		give_verdict();
	end
endmodule : test_dac_parallel_double_buffer
